// *** design/smc_pkg.sv ***
package smc_pkg;

	// ====================================================================
	// sleep mode encodings
	localparam logic [2:0] MODE_IDLE    = 3'h0;
	localparam logic [2:0] MODE_QUIET   = 3'h1;
	localparam logic [2:0] MODE_PDOWN   = 3'h2;
	localparam logic [2:0] MODE_PSAVE   = 3'h3;
	localparam logic [2:0] MODE_STANDBY = 3'h6;

	// ====================================================================
	// control register bit positions
	localparam int BROWNOUT_SLEEP_OFF_BIT_BIT = 6;

	// ====================================================================
	// timing
	localparam int CLK_MHZ          = 100;
	localparam int HALT_EXTRA_CYC   = 4;
	localparam int STANDBY_WAKE_CYC = 6;
	localparam int BOD_WAKE_US      = 60;
	localparam int BOD_WAKE_CYC     = BOD_WAKE_US * CLK_MHZ;
	localparam int STARTUP_CYC_DEF  = 16384;
	localparam int CNT_W            = 16;

	// ====================================================================
	// types
	typedef enum logic [1:0]
	{
		ST_RUN   = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKE  = 2'b10,
		ST_HALT  = 2'b11
	} smc_state_t;

	typedef struct packed
	{
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic osc;
		logic tosc;
	} smc_clk_en_t;

	// wake sources, one bit each
	typedef struct packed
	{
		logic rst;        // external, watchdog or brown-out reset
		logic irq0_level; // level irq on ext_irq_zero
		logic irq0_edge;  // edge irq on ext_irq_zero
		logic ext_other;  // other ext_irq_lines and pin change
		logic start_cond; // serial start condition
		logic timer2;
		logic spm_ready;  // self-program / nonvolatile ready
		logic adc_done;
		logic wdt_irq;
		logic other_io;
	} smc_wake_t;

endpackage : smc_pkg

// *** design/smc_delay.sv ***
`timescale 1ns/1ps
`default_nettype none
// down counter that pulses done once after the loaded count
module smc_delay #(
	parameter int W = 16
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic         busy_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			done     <= 1'b0;
		end
		else if (load)
		begin
			cnt_reg  <= count;
			busy_reg <= 1'b1;
			done     <= 1'b0;
		end
		else if (busy_reg)
		begin
			done <= (cnt_reg <= W'(1));
			if (cnt_reg <= W'(1))
				busy_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - W'(1);
		end
		else
			done <= 1'b0;
	end
endmodule : smc_delay
`default_nettype wire

// *** design/smc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl #(
	parameter int STARTUP_CYC = smc_pkg::STARTUP_CYC_DEF,
	parameter int BOD_CYC     = smc_pkg::BOD_WAKE_CYC
) (
	input  wire logic              MCLK,
	input  wire logic              RST,
	input  wire logic              SLEEP_INSTR,
	input  wire logic              SLEEP_ARM_BIT,
	input  wire logic [2:0]        SLEEP_MODE_SELECT,
	input  wire logic              BROWNOUT_SLEEP_OFF_BIT_WR,
	input  wire logic              BROWNOUT_SLEEP_OFF_BIT_WR_DATA,
	input  wire logic              BROWNOUT_SLEEP_OFF_BIT_UNLOCKED,
	input  wire logic              CRYSTAL_CLOCK,
	input  wire logic              TIMER2_ASYNC,
	input  wire logic              CONVERTER_ENABLED,
	input  wire logic              BROWNOUT_FUSE_ON,
	input  wire smc_pkg::smc_wake_t WAKE_IN,
	output smc_pkg::smc_clk_en_t   CLK_EN,
	output logic                   BROWNOUT_DETECTOR_ON,
	output logic                   BROWNOUT_SLEEP_OFF_BIT,
	output logic                   CONV_START,
	output logic                   SLEEPING,
	output logic                   CPU_HALT,
	output logic                   IRQ_RESUME,
	output logic                   RESET_WAKE
);
	// ====================================================================
	// state
	smc_pkg::smc_state_t state_reg;
	logic [2:0]          mode_reg;
	logic                bod_off_reg;
	logic                brownout_sleep_off_bit_reg;
	logic                load;
	logic [smc_pkg::CNT_W-1:0] wake_cnt;
	logic                delay_done;
	logic [2:0]          halt_reg;
	logic                mode_ok;
	logic                deep;
	logic                wake;

	always_comb
	begin
		mode_ok = (SLEEP_MODE_SELECT == smc_pkg::MODE_IDLE)
			|| (SLEEP_MODE_SELECT == smc_pkg::MODE_QUIET)
			|| (SLEEP_MODE_SELECT == smc_pkg::MODE_PDOWN)
			|| (SLEEP_MODE_SELECT == smc_pkg::MODE_PSAVE)
			|| (SLEEP_MODE_SELECT == smc_pkg::MODE_STANDBY && CRYSTAL_CLOCK);
	end

	assign deep = (mode_reg == smc_pkg::MODE_PDOWN) || (mode_reg == smc_pkg::MODE_PSAVE)
		|| (mode_reg == smc_pkg::MODE_STANDBY);

	// ====================================================================
	// wake decode per mode
	always_comb
	begin
		wake = WAKE_IN.rst;
		unique case (mode_reg)
			smc_pkg::MODE_IDLE:
				wake = wake || WAKE_IN.irq0_level || WAKE_IN.irq0_edge
					|| WAKE_IN.ext_other || WAKE_IN.start_cond
					|| (WAKE_IN.timer2 && TIMER2_ASYNC)
					|| WAKE_IN.spm_ready || WAKE_IN.adc_done
					|| WAKE_IN.wdt_irq || WAKE_IN.other_io;
			smc_pkg::MODE_QUIET:
				wake = wake || WAKE_IN.adc_done || WAKE_IN.irq0_level
					|| WAKE_IN.ext_other || WAKE_IN.start_cond
					|| (WAKE_IN.timer2 && TIMER2_ASYNC)
					|| WAKE_IN.spm_ready || WAKE_IN.wdt_irq;
			smc_pkg::MODE_PSAVE:
				wake = wake || WAKE_IN.irq0_level || WAKE_IN.ext_other
					|| WAKE_IN.start_cond || WAKE_IN.wdt_irq
					|| (WAKE_IN.timer2 && TIMER2_ASYNC);
			default:
				// power-down and standby; level wake relies on the source holding it
				wake = wake || WAKE_IN.irq0_level || WAKE_IN.ext_other
					|| WAKE_IN.start_cond || WAKE_IN.wdt_irq;
		endcase
	end

	// wake delay: fuse start-up for stopped oscillator, six for standby, 60 us if bod was off
	always_comb
	begin
		if (mode_reg == smc_pkg::MODE_STANDBY)
			wake_cnt = smc_pkg::CNT_W'(smc_pkg::STANDBY_WAKE_CYC);
		else if (mode_reg == smc_pkg::MODE_PDOWN || mode_reg == smc_pkg::MODE_PSAVE)
			wake_cnt = smc_pkg::CNT_W'(STARTUP_CYC);
		else
			wake_cnt = smc_pkg::CNT_W'(1);
		// detector settling stretches the wake but never cuts the oscillator start-up
		if (bod_off_reg && smc_pkg::CNT_W'(BOD_CYC) > wake_cnt)
			wake_cnt = smc_pkg::CNT_W'(BOD_CYC);
	end

	assign load = (state_reg == smc_pkg::ST_SLEEP) && wake && !WAKE_IN.rst;

	smc_delay #(
		.W(smc_pkg::CNT_W)
	) u_delay (
		.clk   (MCLK),
		.rst   (RST),
		.load  (load),
		.count (wake_cnt),
		.done  (delay_done)
	);

	// ====================================================================
	// sequencer; register file and memory are never touched here
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg    <= smc_pkg::ST_RUN;
			mode_reg     <= smc_pkg::MODE_IDLE;
			halt_reg     <= 3'h0;
		end
		else
		begin
			unique case (state_reg)
				smc_pkg::ST_RUN:
					if (SLEEP_INSTR && SLEEP_ARM_BIT && mode_ok)
					begin
						state_reg <= smc_pkg::ST_SLEEP;
						mode_reg  <= SLEEP_MODE_SELECT;
					end
				smc_pkg::ST_SLEEP:
					// reset logic runs its own time-out, so no start-up delay here
					if (WAKE_IN.rst)
						state_reg <= smc_pkg::ST_RUN;
					else if (wake)
						state_reg <= smc_pkg::ST_WAKE;
				smc_pkg::ST_WAKE:
					if (delay_done)
					begin
						state_reg <= smc_pkg::ST_HALT;
						halt_reg  <= 3'(smc_pkg::HALT_EXTRA_CYC - 1);
					end
				smc_pkg::ST_HALT:
					if (halt_reg == 3'h0)
						state_reg <= smc_pkg::ST_RUN;
					else
						halt_reg <= halt_reg - 3'h1;
			endcase
		end
	end

	// ====================================================================
	// brown-out sleep bit, writable only inside the unlock window
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			brownout_sleep_off_bit_reg <= 1'b0;
		else if (BROWNOUT_SLEEP_OFF_BIT_WR && BROWNOUT_SLEEP_OFF_BIT_UNLOCKED)
			brownout_sleep_off_bit_reg <= BROWNOUT_SLEEP_OFF_BIT_WR_DATA;
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			bod_off_reg <= 1'b0;
		else if (state_reg == smc_pkg::ST_RUN && SLEEP_INSTR && SLEEP_ARM_BIT && mode_ok)
			// software disable only counts while the fuses have the detector on
			bod_off_reg <= BROWNOUT_FUSE_ON && brownout_sleep_off_bit_reg
				&& (SLEEP_MODE_SELECT == smc_pkg::MODE_PDOWN
				|| SLEEP_MODE_SELECT == smc_pkg::MODE_PSAVE
				|| SLEEP_MODE_SELECT == smc_pkg::MODE_STANDBY);
		else if (state_reg == smc_pkg::ST_RUN)
			bod_off_reg <= 1'b0;
	end

	// ====================================================================
	// outputs
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			CLK_EN                 <= '1;
			BROWNOUT_DETECTOR_ON   <= 1'b0;
			BROWNOUT_SLEEP_OFF_BIT <= 1'b0;
			CONV_START             <= 1'b0;
			SLEEPING               <= 1'b0;
			CPU_HALT               <= 1'b0;
			IRQ_RESUME             <= 1'b0;
			RESET_WAKE             <= 1'b0;
		end
		else
		begin
			BROWNOUT_SLEEP_OFF_BIT <= brownout_sleep_off_bit_reg;
			// detector is off only while asleep; back on as soon as wake starts
			BROWNOUT_DETECTOR_ON   <= BROWNOUT_FUSE_ON
				&& !(state_reg == smc_pkg::ST_SLEEP && bod_off_reg);
			SLEEPING   <= (state_reg == smc_pkg::ST_SLEEP);
			CPU_HALT   <= (state_reg != smc_pkg::ST_RUN);
			IRQ_RESUME <= (state_reg == smc_pkg::ST_HALT) && (halt_reg == 3'h0);
			RESET_WAKE <= (state_reg == smc_pkg::ST_SLEEP) && WAKE_IN.rst;
			CONV_START <= (state_reg == smc_pkg::ST_RUN) && SLEEP_INSTR && SLEEP_ARM_BIT
				&& CONVERTER_ENABLED && (SLEEP_MODE_SELECT == smc_pkg::MODE_IDLE
				|| SLEEP_MODE_SELECT == smc_pkg::MODE_QUIET);
			if (state_reg == smc_pkg::ST_SLEEP)
			begin
				CLK_EN.cpu   <= 1'b0;
				CLK_EN.flash <= 1'b0;
				CLK_EN.io    <= (mode_reg == smc_pkg::MODE_IDLE);
				CLK_EN.adc   <= (mode_reg == smc_pkg::MODE_IDLE)
					|| (mode_reg == smc_pkg::MODE_QUIET);
				CLK_EN.asy   <= !deep || (mode_reg == smc_pkg::MODE_PSAVE);
				CLK_EN.osc   <= !deep || (mode_reg == smc_pkg::MODE_STANDBY);
				CLK_EN.tosc  <= TIMER2_ASYNC && (mode_reg != smc_pkg::MODE_PDOWN)
					&& (mode_reg != smc_pkg::MODE_STANDBY);
			end
			else if (state_reg == smc_pkg::ST_WAKE)
			begin
				// oscillator and peripherals restart, cpu waits for delay
				CLK_EN       <= '1;
				CLK_EN.cpu   <= 1'b0;
				CLK_EN.flash <= 1'b0;
			end
			else
				CLK_EN <= '1;
		end
	end

	// ====================================================================
	// checks
	a_no_sleep_unarmed: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_RUN && SLEEP_INSTR && !SLEEP_ARM_BIT
		|=> state_reg == smc_pkg::ST_RUN)
		else $error("sleep entered without arm bit");

	a_idle_clocks: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && mode_reg == smc_pkg::MODE_IDLE
		|=> !CLK_EN.cpu && CLK_EN.io && CLK_EN.adc)
		else $error("idle clock gating wrong");

	a_quiet_clocks: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && mode_reg == smc_pkg::MODE_QUIET
		|=> !CLK_EN.io && CLK_EN.adc && CLK_EN.asy)
		else $error("quiet clock gating wrong");

	a_pdown_clocks: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && mode_reg == smc_pkg::MODE_PDOWN
		|=> !CLK_EN.osc && !CLK_EN.asy && !CLK_EN.adc)
		else $error("power-down clocks not stopped");

	a_edge_no_wake: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && deep && WAKE_IN == smc_pkg::smc_wake_t'(10'h080)
		|=> state_reg == smc_pkg::ST_SLEEP)
		else $error("edge irq woke deep sleep");

	a_bad_mode_ignored: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_RUN && SLEEP_INSTR && SLEEP_ARM_BIT && !mode_ok
		|=> state_reg == smc_pkg::ST_RUN)
		else $error("unused mode entered sleep");

	a_halt_four: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_WAKE && delay_done
		|=> state_reg == smc_pkg::ST_HALT [*4] ##1 state_reg == smc_pkg::ST_RUN)
		else $error("halt after start-up not four cycles");

	a_brownout_sleep_off_bit_locked: assert property (@(posedge MCLK) disable iff (RST)
		BROWNOUT_SLEEP_OFF_BIT_WR && !BROWNOUT_SLEEP_OFF_BIT_UNLOCKED |=> $stable(brownout_sleep_off_bit_reg))
		else $error("brown-out bit changed while locked");

	a_bod_shallow_on: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && !deep && BROWNOUT_FUSE_ON
		|=> BROWNOUT_DETECTOR_ON)
		else $error("detector off in shallow mode");

	a_reset_wake: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_SLEEP && WAKE_IN.rst
		|=> RESET_WAKE && state_reg == smc_pkg::ST_RUN)
		else $error("reset did not wake to vector");

	a_conv_on_entry: assert property (@(posedge MCLK) disable iff (RST)
		state_reg == smc_pkg::ST_RUN && SLEEP_INSTR && SLEEP_ARM_BIT && CONVERTER_ENABLED
		&& (SLEEP_MODE_SELECT == smc_pkg::MODE_IDLE
		|| SLEEP_MODE_SELECT == smc_pkg::MODE_QUIET)
		|=> CONV_START)
		else $error("no conversion started on sleep entry");

	a_pdown_startup: assert property (@(posedge MCLK) disable iff (RST)
		load && (mode_reg == smc_pkg::MODE_PDOWN || mode_reg == smc_pkg::MODE_PSAVE)
		|-> wake_cnt >= smc_pkg::CNT_W'(STARTUP_CYC))
		else $error("power-down wake shorter than start-up");
endmodule : smc_ctrl
`default_nettype wire

// *** verification/smc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// cpu side and wake sources: a source once raised holds its level
// until the controller reports the wake, so a level wake is never lost
module smc_partner (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               go,
	input  wire smc_pkg::smc_wake_t src,
	input  wire logic               irq_resume,
	input  wire logic               reset_wake,
	output logic                    sleep_instr,
	output smc_pkg::smc_wake_t      wake_in
);
	always_ff @(posedge mclk or posedge rst)
		if (rst)
			sleep_instr <= 1'b0;
		else
			sleep_instr <= go;

	always_ff @(posedge mclk or posedge rst)
		if (rst)
			wake_in <= '0;
		else if (irq_resume | reset_wake)
			wake_in <= '0;
		else
			wake_in <= wake_in | src;
endmodule : smc_partner
`default_nettype wire

// *** verification/tb_smc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_smc_ctrl;
	// ====================================================================
	// short start-up counts keep the run brief
	localparam int SU = 20;
	localparam int BD = 30;
	logic MCLK = 0, RST = 1, go = 0, arm = 0, bw = 0, bd = 0, unl = 0;
	logic xtal = 0, t2a = 0, cen = 0, fuse = 1;
	logic [2:0] mode = 3'h0;
	smc_pkg::smc_wake_t   src = '0, wake_in;
	smc_pkg::smc_clk_en_t clk_en;
	logic sleep_instr, bod_on, brownout_sleep_off_bit_bit, conv, slp, halt, resume, rwake;
	logic exp_brownout_sleep_off_bit = 0, legal, boff;
	logic [9:0] mask;
	int n_fail = 0, checks = 0, nconv = 0, seed = 32'hb902_14de;
	int it, k, n, d;

	initial forever #5 MCLK = ~MCLK;
	always @(posedge MCLK) if (conv === 1'b1) nconv++;

	smc_partner u_smc_partner (.mclk(MCLK), .rst(RST), .go(go), .src(src),
		.irq_resume(resume), .reset_wake(rwake), .sleep_instr(sleep_instr),
		.wake_in(wake_in));

	smc_ctrl #(.STARTUP_CYC(SU), .BOD_CYC(BD)) u_smc_ctrl (.MCLK(MCLK), .RST(RST),
		.SLEEP_INSTR(sleep_instr), .SLEEP_ARM_BIT(arm), .SLEEP_MODE_SELECT(mode),
		.BROWNOUT_SLEEP_OFF_BIT_WR(bw), .BROWNOUT_SLEEP_OFF_BIT_WR_DATA(bd), .BROWNOUT_SLEEP_OFF_BIT_UNLOCKED(unl), .CRYSTAL_CLOCK(xtal),
		.TIMER2_ASYNC(t2a), .CONVERTER_ENABLED(cen), .BROWNOUT_FUSE_ON(fuse),
		.WAKE_IN(wake_in), .CLK_EN(clk_en), .BROWNOUT_DETECTOR_ON(bod_on),
		.BROWNOUT_SLEEP_OFF_BIT(brownout_sleep_off_bit_bit), .CONV_START(conv), .SLEEPING(slp),
		.CPU_HALT(halt), .IRQ_RESUME(resume), .RESET_WAKE(rwake));

	// ====================================================================
	// reference model: gating and wake sets per mode
	function automatic logic [9:0] exp_clk(input logic [2:0] m, input logic a);
		case (m)
			smc_pkg::MODE_IDLE:    return {3'h0, 6'b001111, a};
			smc_pkg::MODE_QUIET:   return {3'h0, 6'b000111, a};
			smc_pkg::MODE_PSAVE:   return {3'h0, 6'b000010, a};
			smc_pkg::MODE_STANDBY: return {3'h0, 7'b0000010};
			default:               return 10'h000;
		endcase
	endfunction : exp_clk

	function automatic logic [9:0] wake_mask(input logic [2:0] m, input logic a);
		// timer2 only wakes while it runs from its own oscillator
		case (m)
			smc_pkg::MODE_IDLE:  return 10'h3ef | (a ? 10'h010 : 10'h000);
			smc_pkg::MODE_QUIET: return 10'h36e | (a ? 10'h010 : 10'h000);
			smc_pkg::MODE_PSAVE: return 10'h362 | (a ? 10'h010 : 10'h000);
			default:             return 10'h362;
		endcase
	endfunction : wake_mask

	// ====================================================================
	// comparisons and verdict
	task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask : chk_val

	task automatic chk_range(input int got, input int lo, input int hi, input string m);
		checks++;
		if (got < lo || got > hi)
		begin
			n_fail++;
			$display("CHECK FAILED %0t %s %0d", $time, m, got);
		end
	endtask : chk_range

	task automatic conclude();
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic tick();
		@(posedge MCLK);
		#1;
	endtask : tick

	initial
	begin
		#500000;
		n_fail++;
		conclude();
	end

	// ====================================================================
	// random sleep cycles over all mode encodings
	initial
	begin
		repeat (12) @(posedge MCLK);
		#1 RST = 0;
		chk_val({3'h0, clk_en}, 10'h07f, "clocks after reset");
		chk_val(brownout_sleep_off_bit_bit, 0, "bod bit reset");
		for (it = 0; it < 60; it++)
		begin
			tick();
			mode = 3'($random(seed));
			arm = ($unsigned($random(seed)) % 4) != 0;
			{xtal, t2a, cen, fuse, unl, bd} = 6'($random(seed));
			bw = 1;
			exp_brownout_sleep_off_bit = unl ? bd : exp_brownout_sleep_off_bit;
			tick();
			bw = 0;
			unl = 0;
			tick();
			chk_val(brownout_sleep_off_bit_bit, exp_brownout_sleep_off_bit, "bod bit write");
			legal = arm && (mode <= 3'h3 || (mode == 3'h6 && xtal));
			boff = fuse && exp_brownout_sleep_off_bit && mode >= 3'h2;
			nconv = 0;
			go = 1;
			tick();
			go = 0;
			repeat (4) tick();
			if (!legal)
			begin
				chk_val(slp, 0, "sleep refused");
				chk_val({3'h0, clk_en}, 10'h07f, "clocks kept");
				continue;
			end
			chk_val(slp, 1, "sleep entered");
			chk_val(halt, 1, "cpu halted in sleep");
			chk_val({3'h0, clk_en}, exp_clk(mode, t2a), "gating");
			chk_val(nconv, cen && mode < 3'h2, "conversion start");
			chk_val(bod_on, fuse && !boff, "detector in sleep");
			mask = wake_mask(mode, t2a);
			k = $unsigned($random(seed)) % 10;
			if (!mask[k])
			begin
				src[k] = 1;
				tick();
				src = '0;
				repeat (10) tick();
				chk_val(slp, 1, "ignored source");
			end
			do
				k = $unsigned($random(seed)) % 10;
			while (!mask[k]);
			src[k] = 1;
			tick();
			src = '0;
			for (n = 0; n < 300 && resume !== 1'b1 && rwake !== 1'b1; n++)
				tick();
			if (k == 9)
			begin
				chk_range(n, 1, 3, "reset wake delay");
				chk_val(rwake, 1, "reset wake flag");
				continue;
			end
			d = mode < 3'h2 ? 1 : (mode == smc_pkg::MODE_STANDBY ? smc_pkg::STANDBY_WAKE_CYC : SU);
			// a stopped detector stretches the wake, never shortens the start-up
			if (boff && BD > d)
				d = BD;
			chk_range(n, d + 4, d + 8, "wake delay");
			chk_val(resume, 1, "resume flag");
			chk_val(bod_on, fuse, "detector back");
			repeat (3) tick();
			chk_val({slp, halt, clk_en}, 10'h07f, "running again");
		end
		conclude();
	end
endmodule : tb_smc_ctrl
`default_nettype wire
